// file: hdl/flash_seq_pkg.sv
// Package for the flash self-programming sequencer: command codes, fields, timing.
// Assumes a single 100 MHz system clock shared with the CPU core.
package flash_seq_pkg;

  // ****************************************
  // Command codes and control layout
  // ****************************************
  localparam logic [7:0] CMD_PAGE_ERASE  = 8'h03;
  localparam logic [7:0] CMD_BUFFER_LOAD = 8'h01;
  localparam logic [7:0] CMD_PAGE_WRITE  = 8'h05;
  localparam int         BUFFER_CLEAR_POS = 4;     // Buffer-clear bit position in control byte
  localparam logic [7:0] CONTROL_RESET    = 8'h00;
  localparam logic [15:0] ERASED_WORD     = 16'hFFFF; // Buffer word value when not loaded

  // ****************************************
  // Pointer fields and timing
  // ****************************************
  localparam int WORD_BITS    = 5;                 // Word-in-page field width (32-word pages)
  localparam int PAGE_LSB     = WORD_BITS;
  localparam int PAGE_BITS    = 7;
  localparam int ARM_WINDOW_CYCLES = 4;            // Store must follow within four clocks
  localparam int CLOCK_MHZ    = 100;
  localparam int PROG_TIME_US = 3700;              // Minimum programming time per operation
  localparam int PROG_CYCLES  = PROG_TIME_US * CLOCK_MHZ;

  // Store request from the CPU core
  typedef struct packed {
    logic        valid;
    logic [15:0] pointer;
    logic [15:0] data;
  } store_req_t;

  // Operation presented to the flash array
  typedef struct packed {
    logic                 erase;
    logic                 write;
    logic [PAGE_BITS-1:0] page;
  } flash_op_t;

endpackage

// file: hdl/flash_self_program_sequencer.sv
// Sequencer that arms self-programming commands from a control byte and executes
// them on the next program-store instruction. Assumes the CPU core presents a one
// cycle store request and obeys the stall output; the flash array reports done.
// All inputs share the system clock, so none of them passes a synchroniser.
// Limitation: a page write programs unloaded words as erased (all ones), so a
// partial page must be reloaded in full before the write.
`timescale 1ns/1ns

// Contract
// - Code 03 plus store erases addressed page
// - Erase page comes from page field only
// - Erase ignores pointer bits outside page field
// - Erase ignores the data word registers
// - CPU stalled for entire page erase
// - Code 01 plus store loads one word
// - Word-in-page field selects buffer location
// - Buffer clears after write or clear bit
// - Buffer clears on system reset
// - Buffer loads accepted in any order
// - Buffer contents survive a page erase
// - Store allowed from any flash address
// - Code 05 plus store writes buffer page
// - CPU stalled for entire page write
// - EEPROM write during loading loses buffer
// - EEPROM write blocks all self-programming
module flash_self_program_sequencer #(
  parameter int PAGE_WORDS  = 32,
  parameter int PROG_COUNT  = flash_seq_pkg::PROG_CYCLES
) (
  // Clock and reset
  input  wire logic                                  CLOCK,
  input  wire logic                                  RSTN,
  // Control byte write from the CPU
  input  wire logic                                  CONTROL_WE,
  input  wire logic [7:0]                            CONTROL_WDATA,
  output logic      [7:0]                            SELF_PROGRAM_CONTROL_STATUS,
  // Program-store instruction
  input  wire flash_seq_pkg::store_req_t             STORE,
  output logic                                       CPU_STALL,
  // Data EEPROM activity
  input  wire logic                                  EEPROM_BUSY,
  // Flash array side
  output flash_seq_pkg::flash_op_t                   FLASH_OP,
  input  wire logic                                  FLASH_DONE,
  input  wire logic [$clog2(PAGE_WORDS)-1:0]         BUFFER_RADDR,
  output logic      [15:0]                           BUFFER_RDATA
);
  import flash_seq_pkg::*;

  typedef enum {IDLE, ARMED, ERASING, WRITING} state_t;
  // Address and counter widths follow the parameters
  localparam int AW = $clog2(PAGE_WORDS);
  localparam int CW = $clog2(PROG_COUNT + 1);

  // Sequencer state
  state_t              state;
  state_t              next_state;
  logic [7:0]          control;
  logic [7:0]          next_control;
  logic [2:0]          arm_count;
  logic [2:0]          next_arm_count;
  logic [CW-1:0]       busy_count;
  logic [CW-1:0]       next_busy_count;
  flash_op_t           op;
  flash_op_t           next_op;
  // Temporary page buffer and its read port
  logic [15:0]         buffer [PAGE_WORDS];
  logic [15:0]         next_rdata;
  logic [PAGE_WORDS-1:0] loaded;
  logic [PAGE_WORDS-1:0] next_loaded;
  // Strobes from the sequencer to the buffer
  logic                clear_buffer;
  logic                load_word;
  logic [AW-1:0]       load_addr;
  logic                eeprom_prev;

  // Page number extracted from the pointer, nothing else looked at
  function automatic logic [PAGE_BITS-1:0] page_of(input logic [15:0] ptr);
    return ptr[PAGE_LSB +: PAGE_BITS];
  endfunction

  // ****************************************
  // Command sequencing
  // ****************************************
  // Arm, fire on store, then hold the CPU until the array reports done and the minimum time has run out
  always_comb begin
    next_state      = state;
    next_control    = control;
    next_arm_count  = arm_count;
    next_busy_count = busy_count;
    next_op         = op;
    clear_buffer    = 1'b0;
    load_word       = 1'b0;
    load_addr       = STORE.pointer[AW-1:0];
    case (state)
      IDLE: begin
        if (CONTROL_WE && !EEPROM_BUSY) begin
          if (CONTROL_WDATA[BUFFER_CLEAR_POS])
            clear_buffer = 1'b1;
          if (CONTROL_WDATA == CMD_PAGE_ERASE || CONTROL_WDATA == CMD_BUFFER_LOAD ||
              CONTROL_WDATA == CMD_PAGE_WRITE) begin
            next_control   = CONTROL_WDATA;
            next_arm_count = 3'h0;
            next_state     = ARMED;
          end
        end
      end
      ARMED: begin
        // Store is honoured from any fetch address; no boot area check
        if (EEPROM_BUSY) begin
          next_control = CONTROL_RESET;
          next_state   = IDLE;
        end else if (STORE.valid) begin
          next_state = IDLE;
          if (control == CMD_PAGE_ERASE) begin
            next_op         = '{erase: 1'b1, write: 1'b0, page: page_of(STORE.pointer)};
            next_busy_count = CW'(PROG_COUNT);
            next_state      = ERASING;                // buffer untouched
          end else if (control == CMD_PAGE_WRITE) begin
            next_op         = '{erase: 1'b0, write: 1'b1, page: page_of(STORE.pointer)};
            next_busy_count = CW'(PROG_COUNT);
            next_state      = WRITING;
          end else begin
            load_word    = 1'b1;
            next_control = CONTROL_RESET;
          end
        // Count runs 0 to 3 after the arming edge: four chances for the store
        end else if (arm_count == 3'(ARM_WINDOW_CYCLES - 1)) begin
          next_control = CONTROL_RESET;
          next_state   = IDLE;
        end else begin
          next_arm_count = arm_count + 3'h1;
        end
      end
      ERASING, WRITING: begin
        // Wait for both the array and the minimum time; either alone is not trusted
        if (busy_count != '0)
          next_busy_count = busy_count - CW'(1);
        if (FLASH_DONE && busy_count == '0) begin
          // Erase leaves the buffer for the write that follows
          if (state == WRITING)
            clear_buffer = 1'b1;
          next_op      = '0;
          next_control = CONTROL_RESET;
          next_state   = IDLE;
        end
      end
      // Unreachable codes fall back to idle rather than lock the CPU
      default: next_state = IDLE;
    endcase
  end

  // Sequencer registers; reset leaves nothing armed and the CPU running
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      state      <= IDLE;
      control    <= CONTROL_RESET;
      arm_count  <= 3'h0;
      busy_count <= '0;
      op         <= '0;
    end else begin
      state      <= next_state;
      control    <= next_control;
      arm_count  <= next_arm_count;
      busy_count <= next_busy_count;
      op         <= next_op;
    end
  end

  // Stall covers the whole erase or write
  assign CPU_STALL = (state == ERASING) || (state == WRITING);
  assign SELF_PROGRAM_CONTROL_STATUS = control;
  assign FLASH_OP = op;

  // ****************************************
  // Temporary page buffer
  // ****************************************
  // Valid bits are what clears; stale storage reads as erased (all ones)
  always_comb begin
    next_loaded = loaded;
    if (clear_buffer || (EEPROM_BUSY && !eeprom_prev))
      next_loaded = '0;
    else if (load_word)
      next_loaded[load_addr] = 1'b1;
  end

  // Valid bits and the previous EEPROM level for its rising edge
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) begin
      loaded      <= '0;
      eeprom_prev <= 1'b0;
    end else begin
      loaded      <= next_loaded;
      eeprom_prev <= EEPROM_BUSY;
    end
  end

  // Storage array without reset keeps it mappable to RAM
  always_ff @(posedge CLOCK) begin
    if (load_word)
      buffer[load_addr] <= STORE.data;
  end

  // Unloaded words read as erased so the array never programs stale storage
  always_comb begin
    next_rdata = ERASED_WORD;
    if (loaded[BUFFER_RADDR])
      next_rdata = buffer[BUFFER_RADDR];
  end

  // Registered read word, one cycle behind the address
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN)
      BUFFER_RDATA <= ERASED_WORD;
    else
      BUFFER_RDATA <= next_rdata;
  end

endmodule

// file: verification/flash_seq_monitor.sv
// Port checker for the flash self-programming sequencer.
// Assumes one clock, reset active low and PROG_COUNT cut down by the bench.
`timescale 1ns/1ns
module flash_seq_monitor
  import flash_seq_pkg::*;
#(parameter int PAGE_WORDS = 32, parameter int PROG_COUNT = 10) (
  // Clock, reset and control
  input wire logic CLOCK, RSTN, CONTROL_WE, CPU_STALL, EEPROM_BUSY, FLASH_DONE,
  input wire logic [7:0] CONTROL_WDATA, SELF_PROGRAM_CONTROL_STATUS,
  // Store, array and buffer
  input wire store_req_t STORE,
  input wire flash_op_t FLASH_OP,
  input wire logic [$clog2(PAGE_WORDS)-1:0] BUFFER_RADDR,
  input wire logic [15:0] BUFFER_RDATA
);
  // *****
  // Properties
  // *****
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  wire [7:0] st = SELF_PROGRAM_CONTROL_STATUS;
  wire idle = st == 8'h00 && !CPU_STALL && !EEPROM_BUSY;
  wire take = STORE.valid && !EEPROM_BUSY && !CPU_STALL;
  property p_arm; idle && CONTROL_WE && CONTROL_WDATA == CMD_PAGE_ERASE |=> st == CMD_PAGE_ERASE; endproperty
  a_arm: assert property (p_arm) else $error("erase code not armed");
  property p_erase; st == CMD_PAGE_ERASE && take |=> CPU_STALL && FLASH_OP.erase
    && FLASH_OP.page == $past(STORE.pointer[11:5]); endproperty
  a_erase: assert property (p_erase) else $error("erase start wrong");
  property p_write; st == CMD_PAGE_WRITE && take |=> CPU_STALL && FLASH_OP.write
    && FLASH_OP.page == $past(STORE.pointer[11:5]); endproperty
  a_write: assert property (p_write) else $error("write start wrong");
  property p_load; st == CMD_BUFFER_LOAD && take |=> st == 8'h00 && !CPU_STALL; endproperty
  a_load: assert property (p_load) else $error("load not finished");
  property p_hold; CPU_STALL && !FLASH_DONE |=> CPU_STALL; endproperty
  a_hold: assert property (p_hold) else $error("stall dropped early");
  property p_expire; st != 8'h00 && !CPU_STALL |-> ##[1:5] (st == 8'h00 || CPU_STALL); endproperty
  a_expire: assert property (p_expire) else $error("armed code outlived window");
  property p_reset; $rose(RSTN) |-> BUFFER_RDATA == 16'hFFFF; endproperty
  a_reset: assert property (p_reset) else $error("buffer not empty after reset");
  property p_wclr; $fell(CPU_STALL) && $past(FLASH_OP.write) |=> BUFFER_RDATA == 16'hFFFF; endproperty
  a_wclr: assert property (p_wclr) else $error("buffer kept after write");
  property p_block; EEPROM_BUSY && !CPU_STALL |=> !CPU_STALL; endproperty
  a_block: assert property (p_block) else $error("operation during eeprom write");
  c_erase: cover property (st == CMD_PAGE_ERASE && take);
  c_write: cover property (st == CMD_PAGE_WRITE && take);
  c_expire: cover property (st == CMD_BUFFER_LOAD ##1 st == 8'h00 && !CPU_STALL);
endmodule
bind flash_self_program_sequencer flash_seq_monitor #(.PAGE_WORDS(PAGE_WORDS), .PROG_COUNT(PROG_COUNT)) mon (
  .CLOCK(CLOCK), .RSTN(RSTN), .CONTROL_WE(CONTROL_WE), .CPU_STALL(CPU_STALL), .EEPROM_BUSY(EEPROM_BUSY),
  .FLASH_DONE(FLASH_DONE), .CONTROL_WDATA(CONTROL_WDATA), .SELF_PROGRAM_CONTROL_STATUS(SELF_PROGRAM_CONTROL_STATUS),
  .STORE(STORE), .FLASH_OP(FLASH_OP), .BUFFER_RADDR(BUFFER_RADDR), .BUFFER_RDATA(BUFFER_RDATA));

// file: verification/flash_array_model.sv
// Flash array stand-in that reports completion of an erase or write.
// Assumes the operation is held steady until completion is seen.
`timescale 1ns/1ns
module flash_array_model (
  // Clock, reset and speed select
  input  wire logic                     CLOCK, RSTN, SLOW,
  // Operation in, completion out
  input  wire flash_seq_pkg::flash_op_t FLASH_OP,
  output logic                          FLASH_DONE
);
  // *****
  // Completion timer
  // *****
  logic [7:0] age;
  wire        busy = FLASH_OP.erase || FLASH_OP.write;
  // Slow mode outlasts the sequencer's own minimum time
  always_ff @(posedge CLOCK or negedge RSTN) begin
    if (!RSTN) age <= 8'h00;
    else if (!busy) age <= 8'h00;
    else if (age != 8'hFF) age <= age + 8'h01;
  end
  assign FLASH_DONE = busy && age >= (SLOW ? 8'h28 : 8'h02);
endmodule

// file: verification/flash_self_program_sequencer_tb.sv
// Bench for the flash self-programming sequencer.
// Assumes PROG_COUNT of 10 and a flash array model on the far side.
`timescale 1ns/1ns
module flash_self_program_sequencer_tb;
  import flash_seq_pkg::*;
  // *****
  // Signals and instances
  // *****
  logic clock = 1'b0, rstn = 1'b0, we = 1'b0, busy = 1'b0, slow = 1'b0, stall, done;
  logic [7:0] wdata = 8'h00, status;
  logic [4:0] raddr = 5'h00;
  logic [15:0] rdata;
  store_req_t st = '0;
  flash_op_t op;
  int fails = 0, total_checks = 0, n;
  always #5 clock = ~clock;
  flash_self_program_sequencer #(.PAGE_WORDS(32), .PROG_COUNT(10)) dut (.CLOCK(clock), .RSTN(rstn),
    .CONTROL_WE(we), .CONTROL_WDATA(wdata), .SELF_PROGRAM_CONTROL_STATUS(status), .STORE(st),
    .CPU_STALL(stall), .EEPROM_BUSY(busy), .FLASH_OP(op), .FLASH_DONE(done), .BUFFER_RADDR(raddr),
    .BUFFER_RDATA(rdata));
  flash_array_model far (.CLOCK(clock), .RSTN(rstn), .SLOW(slow), .FLASH_OP(op), .FLASH_DONE(done));
  // *****
  // Access tasks
  // *****
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic arm(logic [7:0] c);
    @(posedge clock) we <= 1'b1;
    wdata <= c;
    @(posedge clock) we <= 1'b0;
  endtask
  task automatic store(logic [15:0] p, logic [15:0] d);
    @(posedge clock) st <= '{1'b1, p, d};
    @(posedge clock) st.valid <= 1'b0;
  endtask
  task automatic ld(logic [15:0] p, logic [15:0] d);
    arm(CMD_BUFFER_LOAD);
    store(p, d);
  endtask
  task automatic rd(logic [4:0] a, logic [15:0] e);
    @(posedge clock) raddr <= a;
    @(posedge clock);
    #1 chk("buffer word", rdata, e);
  endtask
  // Erase or write, then wait out the stall under a bound
  task automatic run(logic [7:0] c, logic [15:0] p);
    arm(c);
    store(p, 16'h9999);
    #1 chk("operation", {7'h00, op}, {7'h00, c == CMD_PAGE_ERASE, c == CMD_PAGE_WRITE, p[11:5]});
    n = 0;
    while (stall && n < 300) begin
      @(posedge clock);
      #1 n++;
    end
    // Stall ends one edge after both count expiry and array done (age 40 slow; fast done at age 2, so the count of 10 governs)
    chk("stall span", 16'(n), slow ? 16'h0029 : 16'h000B);
    chk("status", {8'h00, status}, 16'h0000);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // *****
  // Scenarios
  // *****
  initial begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    rd(5'h07, 16'hFFFF);
    ld(16'h0067, 16'h1234);
    ld(16'h0062, 16'hABCD);
    rd(5'h07, 16'h1234);
    rd(5'h02, 16'hABCD);
    slow = 1'b1;
    run(CMD_PAGE_ERASE, 16'hF07F);
    rd(5'h07, 16'h1234);
    slow = 1'b0;
    run(CMD_PAGE_WRITE, 16'h0060);
    rd(5'h07, 16'hFFFF);
    arm(CMD_BUFFER_LOAD);
    repeat (6) @(posedge clock);
    #1 chk("expired", {8'h00, status}, 16'h0000);
    store(16'h0061, 16'h5555);
    rd(5'h01, 16'hFFFF);
    ld(16'h0061, 16'h5555);
    arm(8'h10);
    rd(5'h01, 16'hFFFF);
    arm(CMD_BUFFER_LOAD);
    repeat (2) @(posedge clock);
    store(16'h0063, 16'h0F0F);
    rd(5'h03, 16'h0F0F);
    ld(16'h0064, 16'hAAAA);
    @(posedge clock) busy <= 1'b1;
    rd(5'h04, 16'hFFFF);
    arm(CMD_PAGE_ERASE);
    store(16'h0060, 16'h9999);
    #1 chk("blocked", {15'h0000, stall}, 16'h0000);
    chk("blocked op", {7'h00, op}, 16'h0000);
    chk("blocked status", {8'h00, status}, 16'h0000);
    @(posedge clock) busy <= 1'b0;
    ld(16'h0065, 16'h7777);
    @(posedge clock) rstn <= 1'b0;
    @(posedge clock) rstn <= 1'b1;
    rd(5'h05, 16'hFFFF);
    wrap_up;
  end
  // Watchdog far beyond the fewer than two hundred cycles the scenarios need
  initial begin
    repeat (10000) @(posedge clock);
    fails++;
    wrap_up;
  end
endmodule
